// >>> core/nvh_pkg.sv
`default_nettype none

package nvh_pkg;

  // ==========================================================
  // Clock and timing
  localparam int CLK_PERIOD_NS             = 40;
  localparam int ADDRESS_ACCESS_TIME_NS    = 25;
  localparam int WRITE_PULSE_TIME_NS       = 20;
  localparam int WRITE_DATA_SETUP_TIME_NS  = 10;
  localparam int POST_SAVE_LOCKOUT_TIME_NS = 5;
  localparam int HW_REQUEST_TIME_NS        = 500;
  localparam int NV_OP_TIME_NS             = 8000000;

  localparam int ACC_RAW  = (ADDRESS_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACC_CYC  = (ACC_RAW < 1) ? 1 : ACC_RAW;
  localparam int WR_MAXNS = (WRITE_PULSE_TIME_NS > WRITE_DATA_SETUP_TIME_NS) ?
                            WRITE_PULSE_TIME_NS : WRITE_DATA_SETUP_TIME_NS;
  localparam int WR_RAW   = (WR_MAXNS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_CYC   = (WR_RAW < 1) ? 1 : WR_RAW;
  localparam int LOCK_RAW = (POST_SAVE_LOCKOUT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOCK_CYC = (LOCK_RAW < 1) ? 1 : LOCK_RAW;
  localparam int HW_RAW   = (HW_REQUEST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HW_CYC   = (HW_RAW < 2) ? 2 : HW_RAW;
  localparam int NV_CYC   = (NV_OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int CNT_W    = 18;
  localparam int SEQ_LEN  = 6;

  // ==========================================================
  // Software sequence addresses
  localparam logic [15:0] SEQ_PREFIX [0:4] = '{16'h4E38, 16'hB1C7, 16'h83E0,
                                               16'h7C1F, 16'h703F};
  localparam logic [15:0] SEQ_FINAL  [0:3] = '{16'h8FC0, 16'h4C63, 16'h8B45, 16'h4B46};

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    FIN_STORE,
    FIN_RECALL,
    FIN_AS_OFF,
    FIN_AS_ON
  } nvh_fin_t;

  typedef enum logic [2:0] {
    OP_READ,
    OP_WRITE,
    OP_STORE,
    OP_RECALL,
    OP_AS_OFF,
    OP_AS_ON,
    OP_HW_STORE,
    OP_NONE
  } nvh_op_t;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_RD_ACC,
    ST_RD_END,
    ST_WR_SETUP,
    ST_WR_PULSE,
    ST_WR_END,
    ST_SEQ_GAP,
    ST_SEQ_RD,
    ST_HW_REQ,
    ST_NV_WAIT,
    ST_WAIT_HIGH,
    ST_LOCKOUT
  } nvh_state_t;

endpackage
`default_nettype wire

// >>> core/nvh_seq_rom.sv
`timescale 1ns/100ps
`default_nettype none

module nvh_seq_rom (
  input  wire logic          clk_i,
  input  wire logic [2:0]    idx_i,
  input  wire nvh_pkg::nvh_fin_t fin_i,
  output logic      [15:0]   addr_o
);
  import nvh_pkg::*;

  logic [15:0] addr_q;
  wire         is_final = (idx_i >= 3'(SEQ_LEN - 1));
  wire  [15:0] sel_addr = is_final ? SEQ_FINAL[fin_i] : SEQ_PREFIX[idx_i];

  always_ff @(posedge clk_i) begin
    addr_q <= sel_addr;
  end

  assign addr_o = addr_q;

endmodule
`default_nettype wire

// >>> core/nvh_host_ctrl.sv
// Functional notes
// R1 - Read: select and output enable low
// R2 - Only enabled bytes appear on read
// R3 - Read data follows address while selected
// R4 - Address stable through write, data at end
// R5 - Only enabled bytes written
// R6 - Keep output enable high during writes
// R7 - Device turns outputs off late in write
// R8 - Three save triggers, automatic save on
// R9 - Supply loss starts capacitor-powered save
// R10 - Disable automatic save without capacitor
// R11 - Auto and hardware saves need writes
// R12 - Software save always runs
// R13 - Busy pulled low starts delayed save
// R14 - Running write finishes, later writes blocked
// R15 - Clear latch: accesses blocked until release
// R16 - Device holds busy low during save
// R17 - Busy driven high briefly after save
// R18 - Accesses refused briefly after busy rises
// R19 - No accesses during save or restore
// R20 - Host defers accesses while busy low
// R21 - Write enable inactive through host reset
// R22 - Power-up restore holds busy low
// R23 - Six exact consecutive reads, write high
// R24 - Only address bits 14 to 2 compared
// R25 - Sixth address toggles automatic save
// R26 - Write latch set by writes
`timescale 1ns/100ps
`default_nettype none

module nvh_host_ctrl #(
  parameter int ADDR_W      = 19,
  parameter int NV_WAIT_CYC = nvh_pkg::NV_CYC
) (
  input  wire logic                 CLK_I,
  input  wire logic                 RST_B_I,
  input  wire logic                 CAP_FITTED_I,
  input  wire logic                 CMD_VALID_I,
  output logic                      CMD_READY_O,
  input  wire nvh_pkg::nvh_op_t     CMD_OP_I,
  input  wire logic [ADDR_W-1:0]    CMD_ADDR_I,
  input  wire logic [15:0]          CMD_WDATA_I,
  input  wire logic [1:0]           CMD_BE_I,
  output logic                      RSP_VALID_O,
  output logic      [15:0]          RSP_RDATA_O,
  output logic                      DONE_O,
  output logic      [ADDR_W-1:0]    ADDR_O,
  output logic                      CE_N_O,
  output logic                      OE_N_O,
  output logic                      WE_N_O,
  output logic                      UPPER_BYTE_SEL_N_O,
  output logic                      LOWER_BYTE_SEL_N_O,
  input  wire logic [15:0]          DQ_I,
  output logic      [15:0]          DQ_O,
  output logic                      DQ_OE_O,
  input  wire logic                 SAVE_BUSY_LINE_N_I,
  output logic                      SAVE_BUSY_LINE_N_O,
  output logic                      SAVE_BUSY_LINE_N_OE_O
);
  import nvh_pkg::*;

  // ==========================================================
  // State
  nvh_state_t        state_q, state_d;
  logic [CNT_W-1:0]  cnt_q, cnt_d;
  logic [2:0]        idx_q, idx_d;
  nvh_fin_t          fin_q, fin_d;
  logic              boot_q;
  logic [ADDR_W-1:0] addr_q;
  logic [15:0]       wdata_q, rdata_q;
  logic [1:0]        be_q;
  logic              rsp_q, done_q;
  logic              ce_n_q, oe_n_q, we_n_q, dq_oe_q, busy_drv_q;
  logic [15:0]       rom_addr;

  wire cmd_go    = CMD_VALID_I && CMD_READY_O;
  wire cnt_zero  = (cnt_q == '0);
  wire line_high = SAVE_BUSY_LINE_N_I;
  wire seq_last  = (idx_q == 3'(SEQ_LEN - 1));
  wire in_seq    = (state_q == ST_SEQ_GAP) || (state_q == ST_SEQ_RD);

  // Commands wait while the line is low, whoever holds it
  assign CMD_READY_O = (state_q == ST_IDLE) && line_high && !boot_q; // see R20

  nvh_seq_rom u_rom (
    .clk_i  (CLK_I),
    .idx_i  (idx_d),
    .fin_i  (fin_d),
    .addr_o (rom_addr)
  );

  // ==========================================================
  // Next state
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_zero ? '0 : cnt_q - 1'b1;
    idx_d   = idx_q;
    fin_d   = fin_q;
    unique case (state_q)
      ST_IDLE: begin
        if (!line_high) begin
          // Even the boot sequence waits until the line is released
          state_d = ST_WAIT_HIGH; // see R15 R20
        end else if (boot_q && !CAP_FITTED_I) begin
          // Without a backup capacitor an automatic save would corrupt data
          fin_d   = FIN_AS_OFF; // see R10
          idx_d   = '0;
          state_d = ST_SEQ_GAP;
        end else if (cmd_go) begin
          idx_d = '0;
          case (CMD_OP_I)
            OP_READ: begin
              cnt_d   = CNT_W'(ACC_CYC);
              state_d = ST_RD_ACC;
            end
            OP_WRITE:    state_d = ST_WR_SETUP;
            OP_STORE: begin
              fin_d   = FIN_STORE; // see R12
              state_d = ST_SEQ_GAP;
            end
            OP_RECALL: begin
              fin_d   = FIN_RECALL;
              state_d = ST_SEQ_GAP;
            end
            OP_AS_OFF: begin
              fin_d   = FIN_AS_OFF; // see R25
              state_d = ST_SEQ_GAP;
            end
            OP_AS_ON: begin
              fin_d   = FIN_AS_ON; // see R25
              state_d = ST_SEQ_GAP;
            end
            OP_HW_STORE: begin
              cnt_d   = CNT_W'(HW_CYC - 1);
              state_d = ST_HW_REQ;
            end
            default: state_d = ST_IDLE;
          endcase
        end
      end
      ST_RD_ACC:   if (cnt_zero) state_d = ST_RD_END; // see R1
      ST_RD_END:   state_d = ST_IDLE;
      ST_WR_SETUP: begin
        cnt_d   = CNT_W'(WR_CYC - 1);
        state_d = ST_WR_PULSE;
      end
      ST_WR_PULSE: if (cnt_zero) state_d = ST_WR_END; // see R4
      ST_WR_END:   state_d = ST_IDLE;
      ST_SEQ_GAP: begin
        cnt_d   = CNT_W'(ACC_CYC);
        state_d = ST_SEQ_RD;
      end
      ST_SEQ_RD: begin
        if (cnt_zero) begin
          if (seq_last) begin
            cnt_d   = CNT_W'(NV_WAIT_CYC - 1);
            state_d = ST_NV_WAIT; // see R19
          end else begin
            idx_d   = idx_q + 3'h1; // see R23
            state_d = ST_SEQ_GAP;
          end
        end
      end
      // Pull the line long enough to cover the device's start delay
      ST_HW_REQ:   if (cnt_zero) state_d = ST_WAIT_HIGH; // see R13
      ST_NV_WAIT:  if (cnt_zero) state_d = ST_WAIT_HIGH; // see R19
      ST_WAIT_HIGH: begin
        if (line_high) begin
          cnt_d   = CNT_W'(LOCK_CYC - 1);
          state_d = ST_LOCKOUT; // see R16
        end
      end
      ST_LOCKOUT:  if (cnt_zero) state_d = ST_IDLE; // see R18
    endcase
  end

  // ==========================================================
  // Pin decode from the next state, so every pin leaves a flop
  wire ce_on  = (state_d == ST_RD_ACC) || (state_d == ST_WR_PULSE) || (state_d == ST_SEQ_RD);
  wire oe_on  = (state_d == ST_RD_ACC) || (state_d == ST_SEQ_RD); // see R6
  wire we_on  = (state_d == ST_WR_PULSE);
  wire dq_on  = (state_d == ST_WR_PULSE) || (state_d == ST_WR_END);
  wire hw_on  = (state_d == ST_HW_REQ);
  wire ld_cmd = cmd_go && ((CMD_OP_I == OP_READ) || (CMD_OP_I == OP_WRITE));
  wire ld_seq = (state_q == ST_SEQ_GAP);
  wire [15:0] rd_mask = {{8{be_q[1]}}, {8{be_q[0]}}};

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      state_q    <= ST_IDLE;
      cnt_q      <= '0;
      idx_q      <= '0;
      fin_q      <= FIN_STORE;
      boot_q     <= 1'b1;
      ce_n_q     <= 1'b1;
      oe_n_q     <= 1'b1;
      we_n_q     <= 1'b1; // see R21
      dq_oe_q    <= 1'b0;
      busy_drv_q <= 1'b0;
      rsp_q      <= 1'b0;
      done_q     <= 1'b0;
    end else begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      idx_q      <= idx_d;
      fin_q      <= fin_d;
      boot_q     <= boot_q && !((state_q == ST_IDLE) && line_high);
      ce_n_q     <= !ce_on;
      oe_n_q     <= !oe_on;
      we_n_q     <= !we_on;
      dq_oe_q    <= dq_on;
      busy_drv_q <= hw_on;
      rsp_q      <= (state_q == ST_RD_ACC) && cnt_zero;
      done_q     <= (state_q == ST_LOCKOUT) && cnt_zero;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      addr_q  <= '0;
      wdata_q <= '0;
      be_q    <= '0;
      rdata_q <= '0;
    end else begin
      if (ld_cmd) begin
        addr_q  <= CMD_ADDR_I;
        wdata_q <= CMD_WDATA_I;
        be_q    <= CMD_BE_I; // see R5
      end else if (ld_seq) begin
        // Upper address bits are don't care to the decoder; drive zero
        addr_q <= {{(ADDR_W-16){1'b0}}, rom_addr}; // see R24
        be_q   <= 2'h3;
      end
      if ((state_q == ST_RD_ACC) && cnt_zero) begin
        rdata_q <= DQ_I & rd_mask; // see R2
      end
    end
  end

  assign ADDR_O                = addr_q;
  assign CE_N_O                = ce_n_q;
  assign OE_N_O                = oe_n_q;
  assign WE_N_O                = we_n_q;
  assign UPPER_BYTE_SEL_N_O    = !be_q[1];
  assign LOWER_BYTE_SEL_N_O    = !be_q[0];
  assign DQ_O                  = wdata_q;
  assign DQ_OE_O               = dq_oe_q;
  assign SAVE_BUSY_LINE_N_O    = 1'b0;
  assign SAVE_BUSY_LINE_N_OE_O = busy_drv_q;
  assign RSP_VALID_O           = rsp_q;
  assign RSP_RDATA_O           = rdata_q;
  assign DONE_O                = done_q;

  // ==========================================================
  // Checks
  logic [2:0] seq_reads_q;

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I || (state_q == ST_IDLE)) begin
      seq_reads_q <= '0;
    end else if (ld_seq) begin
      seq_reads_q <= seq_reads_q + 3'h1;
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);

  sequence s_write_low;
    WE_N_O ##1 !WE_N_O;
  endsequence

  sequence s_seq_done;
    (state_q == ST_SEQ_RD) && (state_d == ST_NV_WAIT);
  endsequence

  a_we_after_reset: assert property ($rose(RST_B_I) |-> WE_N_O) // see R21
    else $error("write enable active after reset");
  a_oe_in_write: assert property (!WE_N_O |-> OE_N_O && !CE_N_O && DQ_OE_O) // see R6
    else $error("output enable low or data off during write");
  a_addr_in_write: assert property (s_write_low |-> $stable(ADDR_O)) // see R4
    else $error("address moved inside write");
  a_addr_write_end: assert property ($rose(WE_N_O) |-> $stable(ADDR_O) && DQ_OE_O) // see R4
    else $error("address or data dropped at write end");
  a_idle_line_low: assert property (!SAVE_BUSY_LINE_N_I && CE_N_O |=> CE_N_O) // see R20
    else $error("access started while busy line low");
  a_seq_we_high: assert property (in_seq |-> WE_N_O && !DQ_OE_O) // see R23
    else $error("write enable low inside sequence");
  a_seq_six_reads: assert property (s_seq_done |-> seq_reads_q == 3'h6) // see R23
    else $error("sequence did not issue six reads");
  a_boot_disable: assert property (
    $rose(RST_B_I) && !CAP_FITTED_I |-> ##[1:4] (!CE_N_O && ADDR_O[15:0] == 16'h4E38)) // see R10
    else $error("no disable sequence without capacitor");
  a_lockout_idle: assert property (
    (state_q == ST_LOCKOUT) || (state_q == ST_WAIT_HIGH) |-> CE_N_O) // see R18
    else $error("access during save lockout");
  a_hw_pulse_len: assert property ($rose(SAVE_BUSY_LINE_N_OE_O) |=> SAVE_BUSY_LINE_N_OE_O) // see R13
    else $error("hardware request pulse too short");
  a_read_response: assert property (
    RSP_VALID_O |-> $past(!OE_N_O) && $past(!CE_N_O) && OE_N_O) // see R1
    else $error("read answer without an output enable window");

endmodule
`default_nettype wire

// >>> dv/nvh_nv_mem_model.sv
`timescale 1ns/100ps
`default_nettype none

module nvh_nv_mem_model #(
  parameter int NVC = 30,
  parameter int RCC = 10,
  parameter int PUC = 2
) (
  input  wire logic        clk_i,
  input  wire logic [18:0] addr_i,
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic        ub_n_i,
  input  wire logic        lb_n_i,
  input  wire logic [15:0] dq_i,
  output logic      [15:0] dq_o,
  input  wire logic        busy_n_i,
  output logic             busy_n_o,
  output logic             busy_n_oe_o,
  output logic             as_en_o,
  output logic      [7:0]  saves_o,
  input  wire logic        pwr_fail_i
);
  localparam logic [15:0] SQ [0:8] = '{16'h4E38, 16'hB1C7, 16'h83E0, 16'h7C1F, 16'h703F,
                                       16'h8FC0, 16'h4C63, 16'h8B45, 16'h4B46};
  logic [15:0] mem [0:255];
  logic [15:0] nv  [0:255];
  logic [15:0] pat_q = 16'h5A5A, wd_q, wm_q;
  logic [7:0]  wa_q, saves_q = 8'h00;
  logic        latch_q = 1'b0, rd_q = 1'b0, wr_q = 1'b0, wr_ok_q = 1'b0, as_q = 1'b1, go;
  int          busy_c = PUC, hi_c = 0, blk_c = 0, hw_c = 0, idx = 0, i;
  wire  [15:0] msk = {{8{!ub_n_i}}, {8{!lb_n_i}}};
  wire  [12:0] sel = addr_i[14:2];
  wire         rd  = !ce_n_i && !oe_n_i && we_n_i && busy_n_i && blk_c == 0;
  wire         wr  = !ce_n_i && !we_n_i;

  // ==========
  // Pins
  // Released lanes toggle every cycle so stale data never passes for a read
  assign dq_o        = rd ? (mem[addr_i[7:0]] & msk) | (pat_q & ~msk) : pat_q;
  assign busy_n_o    = busy_c == 0;
  assign busy_n_oe_o = busy_c > 0 || hi_c > 0;
  assign as_en_o     = as_q;
  assign saves_o     = saves_q;

  initial begin
    for (i = 0; i < 256; i++) begin
      mem[i] = 16'h0000;
      nv[i]  = 16'h0000;
    end
  end

  // ==========
  // Cell behaviour
  always @(negedge clk_i) begin
    go = 1'b0;
    pat_q <= ~pat_q;
    rd_q  <= rd;
    wr_q  <= wr;
    hw_c  <= (!busy_n_i && busy_c == 0 && hi_c == 0) ? hw_c + 1 : 0;
    if (busy_c > 0) begin
      busy_c <= busy_c - 1;
      hi_c   <= 2;
      blk_c  <= 1;
    end else begin
      if (hi_c > 0)
        hi_c <= hi_c - 1;
      if (blk_c > 0)
        blk_c <= blk_c - 1;
    end
    if (wr && !wr_q)
      wr_ok_q <= busy_n_i && busy_c == 0 && blk_c == 0;
    if (wr) begin
      wd_q <= dq_i;
      wm_q <= msk;
      wa_q <= addr_i[7:0];
    end
    if (!wr && wr_q && wr_ok_q) begin
      mem[wa_q] <= (mem[wa_q] & ~wm_q) | (wd_q & wm_q);
      latch_q   <= 1'b1;
      idx       <= 0;
    end
    if (rd && !rd_q) begin
      if (idx < 5)
        idx <= (sel == SQ[idx][14:2]) ? idx + 1 : int'(sel == SQ[0][14:2]);
      else begin
        idx <= 0;
        go = sel == SQ[5][14:2];
        if (sel == SQ[6][14:2]) begin
          for (i = 0; i < 256; i++)
            mem[i] <= nv[i];
          latch_q <= 1'b0;
          blk_c   <= RCC;
        end
        if (sel == SQ[7][14:2])
          as_q <= 1'b0;
        if (sel == SQ[8][14:2])
          as_q <= 1'b1;
      end
    end
    if (hw_c == 4 && latch_q)
      go = 1'b1;
    if (pwr_fail_i && as_q && latch_q)
      go = 1'b1;
    if (go) begin
      for (i = 0; i < 256; i++)
        nv[i] <= mem[i];
      latch_q <= 1'b0;
      busy_c  <= NVC;
      saves_q <= saves_q + 8'h01;
    end
  end
endmodule

`default_nettype wire

// >>> dv/nvsram_access_and_save_control_tb.sv
`timescale 1ns/100ps
`default_nettype none

module nvsram_access_and_save_control_tb;
  import nvh_pkg::*;

  logic        clk, rst_b, cap, vld, rdy, rsp_v, done, ce_n, oe_n, we_n, ub_n, lb_n;
  logic        dq_oe, hb_o, hb_oe, m_o, m_oe, as_en, wq, pf;
  nvh_op_t     op;
  logic [18:0] addr, pin_a;
  logic [15:0] wd, rdat, dq_h, dq_m, wa, lv;
  logic [1:0]  be;
  logic [7:0]  saves;
  logic [31:0] r;
  logic [15:0] sh [0:255];
  logic [15:0] expq [$];
  logic [18:0] al [0:15];
  logic [1:0]  bl [0:15];
  int          err_total, n_tests, seed, k;
  wire         line = !((hb_oe && !hb_o) || (m_oe && !m_o));
  wire  [15:0] dq   = dq_oe ? dq_h : dq_m;

  nvh_host_ctrl #(.NV_WAIT_CYC(20)) uut (
    .CLK_I(clk), .RST_B_I(rst_b), .CAP_FITTED_I(cap), .CMD_VALID_I(vld), .CMD_READY_O(rdy),
    .CMD_OP_I(op), .CMD_ADDR_I(addr), .CMD_WDATA_I(wd), .CMD_BE_I(be), .RSP_VALID_O(rsp_v),
    .RSP_RDATA_O(rdat), .DONE_O(done), .ADDR_O(pin_a), .CE_N_O(ce_n), .OE_N_O(oe_n),
    .WE_N_O(we_n), .UPPER_BYTE_SEL_N_O(ub_n), .LOWER_BYTE_SEL_N_O(lb_n), .DQ_I(dq),
    .DQ_O(dq_h), .DQ_OE_O(dq_oe), .SAVE_BUSY_LINE_N_I(line), .SAVE_BUSY_LINE_N_O(hb_o),
    .SAVE_BUSY_LINE_N_OE_O(hb_oe));

  nvh_nv_mem_model dev (
    .clk_i(clk), .addr_i(pin_a), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .ub_n_i(ub_n),
    .lb_n_i(lb_n), .dq_i(dq), .dq_o(dq_m), .busy_n_i(line), .busy_n_o(m_o),
    .busy_n_oe_o(m_oe), .as_en_o(as_en), .saves_o(saves), .pwr_fail_i(pf));

  // ==========
  // Checking
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic hang(input string nm);
    chk(nm, 16'h0001, 16'h0000);
    stop_test();
  endtask

  always @(negedge clk) begin
    if (rsp_v === 1'b1) begin
      if (expq.size() == 0)
        chk("spare read answer", 16'h0000, 16'h0001);
      else
        chk("read data", expq.pop_front(), rdat);
    end
    if (we_n === 1'b0 && oe_n === 1'b0)
      chk("output enable in write", 16'h0001, {15'h0000, oe_n});
    if (wq && we_n === 1'b1)
      chk("write address hold", wa, pin_a[15:0]);
    wq <= we_n === 1'b0;
    wa <= pin_a[15:0];
  end

  // ==========
  // Drivers
  task automatic issue(input nvh_op_t o, input logic [18:0] a, input logic [15:0] d,
                       input logic [1:0] b);
    int n;
    @(posedge clk);
    op   <= o;
    addr <= a;
    wd   <= d;
    be   <= b;
    vld  <= 1'b1;
    // Ready is read before this edge's updates, so it is what the design samples
    for (n = 0; n < 3000; n++) begin
      @(posedge clk);
      if (rdy === 1'b1)
        break;
    end
    if (n == 3000)
      hang("command ready");
    vld <= 1'b0;
  endtask

  task automatic wait_done;
    int n;
    for (n = 0; n < 3000; n++) begin
      @(negedge clk);
      if (done === 1'b1)
        break;
    end
    if (n == 3000)
      hang("done pulse");
  endtask

  task automatic wr(input logic [18:0] a, input logic [15:0] d, input logic [1:0] b);
    logic [15:0] m;
    m = {{8{b[1]}}, {8{b[0]}}};
    sh[a[7:0]] = (sh[a[7:0]] & ~m) | (d & m);
    issue(OP_WRITE, a, d, b);
  endtask

  task automatic rdx(input logic [18:0] a, input logic [1:0] b);
    expq.push_back(sh[a[7:0]] & {{8{b[1]}}, {8{b[0]}}});
    issue(OP_READ, a, 16'h0000, b);
  endtask

  task automatic nvop(input nvh_op_t o);
    issue(o, 19'h00000, 16'h0000, 2'h0);
    wait_done();
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    seed = 32'hCE11;
    err_total = 0;
    n_tests = 0;
    rst_b = 1'b0;
    cap = 1'b0;
    vld = 1'b0;
    op = OP_NONE;
    addr = 19'h00000;
    wd = 16'h0000;
    be = 2'h0;
    wq = 1'b0;
    pf = 1'b0;
    for (k = 0; k < 256; k++)
      sh[k] = 16'h0000;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    wait_done();
    chk("auto save enable", 16'h0000, {15'h0000, as_en});
    $display("test boot done");
    for (k = 0; k < 16; k++) begin
      r = $random(seed);
      al[k] = {11'h000, r[7:0]};
      bl[k] = (r[9:8] == 2'h0) ? 2'h3 : r[9:8];
      wr(al[k], r[31:16], bl[k]);
    end
    for (k = 0; k < 16; k++)
      rdx(al[k], k[0] ? 2'h3 : bl[k]);
    $display("test read write done");
    @(posedge clk);
    pf <= 1'b1;
    @(posedge clk);
    pf <= 1'b0;
    repeat (4) @(posedge clk);
    chk("save count", 16'h0000, {8'h00, saves});
    lv = sh[al[0][7:0]];
    nvop(OP_STORE);
    nvop(OP_STORE);
    chk("save count", 16'h0002, {8'h00, saves});
    nvop(OP_AS_ON);
    chk("auto save enable", 16'h0001, {15'h0000, as_en});
    wr(al[0], 16'hA5C3, 2'h3);
    nvop(OP_RECALL);
    sh[al[0][7:0]] = lv;
    rdx(al[0], 2'h3);
    $display("test software save done");
    nvop(OP_HW_STORE);
    chk("save count", 16'h0002, {8'h00, saves});
    wr(al[1], 16'h3C5A, 2'h1);
    nvop(OP_HW_STORE);
    chk("save count", 16'h0003, {8'h00, saves});
    rdx(al[1], 2'h3);
    repeat (8) @(posedge clk);
    chk("pending reads", 16'h0000, 16'(expq.size()));
    $display("test hardware save done");
    wr(al[2], 16'h0FF0, 2'h3);
    repeat (4) @(posedge clk);
    pf <= 1'b1;
    @(posedge clk);
    pf <= 1'b0;
    wait_done();
    chk("save count", 16'h0004, {8'h00, saves});
    $display("test power loss done");
    stop_test();
  end
endmodule

`default_nettype wire
